// ==== core/lom_comp.sv ====
`timescale 1ns/1ps
// Lost motion compensation core with APB register slave
module lom_comp #(
  parameter int CYC_PER_MS = lom_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Servo loop
  input  wire logic        sample_tick,
  input  wire logic [31:0] pos_cmd,
  input  wire logic        ff_active,
  input  wire logic [15:0] torque_in,
  output logic      [15:0] torque_out,
  output logic      [15:0] collision_offset,
  // Interrupt
  output logic             irq
);
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] ctrl;
    logic [15:0] amt_pri;
    logic [15:0] amt_sec;
    logic [15:0] ofs;
    logic [10:0] dly;
    logic [6:0]  band;
    logic [15:0] gain;
    logic [3:0]  sts;
    logic [3:0]  mask;
    logic        irq;
    logic        pend_neg;
    logic        arm;
    logic [15:0] comp;
    logic [15:0] torque;
    logic [15:0] coll;
  } lom_comp_s;
  lom_comp_s q, d;

  logic [31:0] model_pos;
  logic        dir_neg;
  logic        rev;
  logic        rev_neg;
  logic        dly_busy;
  logic        fire;
  logic [6:0]  eff_band;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        err;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic        type_on;
  logic [15:0] amt;
  int          raw;

  function automatic logic in_range(input logic [31:0] v, input int lo, input int hi);
    return $signed(v) >= lo && $signed(v) <= hi;
  endfunction

  function automatic logic [15:0] sat16(input int v);
    if (v > 32767) begin
      return 16'h7FFF;
    end else if (v < -32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  // Amount for the new direction; zero borrows the other side
  function automatic logic [15:0] pick_amt(input logic neg, input logic [15:0] pri, input logic [15:0] sec);
    logic [15:0] own;
    logic [15:0] other;
    own   = neg ? sec : pri;
    other = neg ? pri : sec;
    return (own == 16'h0000) ? other : own;
  endfunction

  function automatic logic ctrl_ok(input logic [15:0] v);
    if (v[lom_pkg::SEL_TYPE_LOW] && v[lom_pkg::SEL_TYPE_HIGH]) begin
      return 1'b0;
    end
    if (v[lom_pkg::SEL_TYPE_LOW] && (v[lom_pkg::SEL_OVS] || v[lom_pkg::SEL_AFT])) begin
      return 1'b0;
    end
    return 1'b1;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a <= lom_pkg::ADDR_MODEL && a[1:0] == 2'b00;
  endfunction

  // Dead band only matters under feed-forward; zero means the minimum
  assign eff_band = !ff_active ? 7'h00 :
                    (q.band == 7'h00) ? lom_pkg::BAND_ZERO_UM : q.band;

  lom_model u_model (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .sample_tick (sample_tick),
    .pos_cmd     (pos_cmd),
    .gain        (q.gain),
    .band        (eff_band),
    .model_pos   (model_pos),
    .dir_neg     (dir_neg),
    .rev         (rev),
    .rev_neg     (rev_neg)
  );

  lom_delay #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_delay (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (rev),
    .delay_ms (q.dly),
    .busy     (dly_busy),
    .fire     (fire)
  );

  always_comb begin
    d = q;
    acc = psel & penable & q.pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    err = 1'b0;
    ev = 4'h0;
    amt = 16'h0000;
    raw = 0;
    type_on = q.ctrl[lom_pkg::SEL_TYPE_LOW] ^ q.ctrl[lom_pkg::SEL_TYPE_HIGH];
    // Answer in the second access cycle; data captured one edge before
    d.pready = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata = 32'h00000000;
    if (psel & penable & ~q.pready) begin
      d.pslverr = ~mapped(paddr);
      case (paddr)
        lom_pkg::ADDR_CTRL:    d.prdata = {16'h0000, q.ctrl};
        lom_pkg::ADDR_AMT_PRI: d.prdata = 32'($signed(q.amt_pri));
        lom_pkg::ADDR_AMT_SEC: d.prdata = 32'($signed(q.amt_sec));
        lom_pkg::ADDR_OFFSET:  d.prdata = 32'($signed(q.ofs));
        lom_pkg::ADDR_DELAY:   d.prdata = {21'h000000, q.dly};
        lom_pkg::ADDR_BAND:    d.prdata = {25'h0000000, q.band};
        lom_pkg::ADDR_GAIN:    d.prdata = {16'h0000, q.gain};
        lom_pkg::ADDR_STATUS:  d.prdata = {28'h0000000, q.sts};
        lom_pkg::ADDR_MASK:    d.prdata = {28'h0000000, q.mask};
        lom_pkg::ADDR_STATE:   d.prdata = {26'h0000000, q.ctrl[9:8], q.arm, dly_busy, q.pend_neg, dir_neg};
        lom_pkg::ADDR_MODEL:   d.prdata = model_pos;
        default:               d.prdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (paddr)
        lom_pkg::ADDR_CTRL: begin
          if (ctrl_ok(pwdata[15:0]) && pwdata[31:16] == 16'h0000) d.ctrl = pwdata[15:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_AMT_PRI: begin
          if (in_range(pwdata, lom_pkg::AMT_MIN, lom_pkg::AMT_MAX)) d.amt_pri = pwdata[15:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_AMT_SEC: begin
          if (in_range(pwdata, lom_pkg::AMT_MIN, lom_pkg::AMT_MAX)) d.amt_sec = pwdata[15:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_OFFSET: begin
          if (in_range(pwdata, lom_pkg::OFS_MIN, lom_pkg::OFS_MAX)) d.ofs = pwdata[15:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_DELAY: begin
          if (in_range(pwdata, 0, lom_pkg::DLY_MAX_MS)) d.dly = pwdata[10:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_BAND: begin
          if (in_range(pwdata, 0, lom_pkg::BAND_MAX_UM)) d.band = pwdata[6:0];
          else err = 1'b1;
        end
        lom_pkg::ADDR_GAIN: d.gain = pwdata[15:0];
        lom_pkg::ADDR_MASK: d.mask = pwdata[3:0];
        default: d.gain = q.gain;
      endcase
    end
    ev[lom_pkg::STS_PARAM_ERR] = err;
    // Collision detection sees the offset; the plain torque path does not
    d.coll = sat16(int'($signed(q.ofs)) * lom_pkg::TORQUE_PER_PCT);
    // Plain path every tick, compensation only on the armed tick
    if (sample_tick) begin
      if (q.arm) begin
        d.torque = sat16(int'($signed(torque_in)) + int'($signed(q.comp)));
        d.arm = 1'b0;
        ev[lom_pkg::STS_APPLIED] = 1'b1;
      end else begin
        d.torque = torque_in;
      end
    end
    if (rev) begin
      d.pend_neg = rev_neg;
      ev[rev_neg ? lom_pkg::STS_REV_NEG : lom_pkg::STS_REV_POS] = 1'b1;
    end
    if (fire) begin
      amt = pick_amt(q.pend_neg, q.amt_pri, q.amt_sec);
      raw = (q.pend_neg ? -int'($signed(amt)) : int'($signed(amt))) + int'($signed(q.ofs));
      if (type_on && amt != 16'hFFFF && amt != 16'h0000) begin
        d.arm = 1'b1;
        d.comp = sat16(raw * lom_pkg::TORQUE_PER_PCT);
      end
    end
    // Only bits that were reported are cleared, so a new event survives
    clr = (rd && paddr == lom_pkg::ADDR_STATUS) ? q.prdata[3:0] : 4'h0;
    d.sts = (q.sts & ~clr) | ev;
    d.irq = |(d.sts & d.mask);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.ctrl <= lom_pkg::RST_CTRL;
      q.gain <= lom_pkg::RST_GAIN;
      q.mask <= lom_pkg::RST_MASK;
    end else begin
      q <= d;
    end
  end

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign torque_out       = q.torque;
  assign collision_offset = q.coll;
  assign irq              = q.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_write_done;
    psel && penable && pready && pwrite;
  endsequence
  sequence s_apply_tick;
    sample_tick && q.arm;
  endsequence

  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
  a_unmapped_error: assert property (psel && penable && !pready && !mapped(paddr) |=> pready && pslverr)
    else $error("unmapped address not flagged");
  a_type1_interlock: assert property (s_write_done ##0
    (paddr == lom_pkg::ADDR_CTRL && pwdata[8] && pwdata[10]) |=> $stable(q.ctrl) && q.sts[lom_pkg::STS_PARAM_ERR])
    else $error("type 1 interlock missed");
  a_dual_type_refused: assert property (s_write_done ##0
    (paddr == lom_pkg::ADDR_CTRL && pwdata[9:8] == 2'b11) |=> $stable(q.ctrl))
    else $error("prohibited type accepted");
  a_amount_range: assert property (s_write_done ##0
    (paddr == lom_pkg::ADDR_AMT_PRI && $signed(pwdata) > 200) |=> $stable(q.amt_pri))
    else $error("amount out of range stored");
  a_offset_range: assert property (s_write_done ##0
    (paddr == lom_pkg::ADDR_OFFSET && ($signed(pwdata) < -100 || $signed(pwdata) > 100)) |=> $stable(q.ofs))
    else $error("offset out of range stored");
  a_plain_torque: assert property (sample_tick && !q.arm |=> torque_out == $past(torque_in))
    else $error("torque altered without compensation");
  a_comp_once: assert property (s_apply_tick |=> !q.arm && q.sts[lom_pkg::STS_APPLIED]
    && torque_out == sat16(int'($signed($past(torque_in))) + int'($signed($past(q.comp)))))
    else $error("compensation not applied once");
  a_no_type_no_comp: assert property (fire && !type_on |=> !q.arm) else $error("compensation without type");
  a_band_no_ff: assert property (!ff_active |-> eff_band == 7'h00) else $error("dead band active without ff");
  a_band_zero_min: assert property (ff_active && q.band == 7'h00 |-> eff_band == lom_pkg::BAND_ZERO_UM)
    else $error("zero dead band not 2 um");
  a_irq_level: assert property (irq == |(q.sts & q.mask)) else $error("irq mismatch");

  sequence s_reversal;
    rev;
  endsequence
  sequence s_fire_idle;
    fire && !q.arm;
  endsequence

  // Refused settings can never be found in the stored registers
  a_ctrl_one_type: assert property (!(q.ctrl[lom_pkg::SEL_TYPE_LOW] && q.ctrl[lom_pkg::SEL_TYPE_HIGH]))
    else $error("both type bits stored");
  a_type1_exclusive: assert property (q.ctrl[lom_pkg::SEL_TYPE_LOW] |-> !q.ctrl[lom_pkg::SEL_OVS]
    && !q.ctrl[lom_pkg::SEL_AFT]) else $error("type 1 stored beside overshoot or filter");
  a_amounts_held: assert property (
    $signed(q.amt_pri) >= lom_pkg::AMT_MIN && $signed(q.amt_pri) <= lom_pkg::AMT_MAX
    && $signed(q.amt_sec) >= lom_pkg::AMT_MIN && $signed(q.amt_sec) <= lom_pkg::AMT_MAX)
    else $error("stored amount out of range");
  a_offset_held: assert property (
    $signed(q.ofs) >= lom_pkg::OFS_MIN && $signed(q.ofs) <= lom_pkg::OFS_MAX)
    else $error("stored offset out of range");
  a_limits_held: assert property (
    int'(q.dly) <= lom_pkg::DLY_MAX_MS && int'(q.band) <= lom_pkg::BAND_MAX_UM)
    else $error("stored delay or band out of range");
  a_rev_starts_delay: assert property (s_reversal |=> dly_busy) else $error("delay not started");
  a_rev_pos_status: assert property (s_reversal ##0 !rev_neg |=> q.sts[lom_pkg::STS_REV_POS])
    else $error("positive reversal not reported");
  a_rev_neg_status: assert property (s_reversal ##0 rev_neg |=> q.sts[lom_pkg::STS_REV_NEG])
    else $error("negative reversal not reported");
  a_minus_one_blocks: assert property (s_fire_idle ##0 ((q.pend_neg ? q.amt_sec : q.amt_pri) == 16'hFFFF)
    |=> !q.arm) else $error("disabled direction compensated");
  a_zero_borrows: assert property (s_fire_idle ##0 (type_on && q.pend_neg && q.amt_sec == 16'h0000
    && q.amt_pri != 16'h0000 && q.amt_pri != 16'hFFFF) |=> q.arm) else $error("zero amount not borrowed");
endmodule

// ==== core/lom_pkg.sv ====
// Constants shared by the lost motion compensation block
package lom_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_AMT_PRI = 8'h04;
  localparam logic [7:0] ADDR_AMT_SEC = 8'h08;
  localparam logic [7:0] ADDR_OFFSET  = 8'h0C;
  localparam logic [7:0] ADDR_DELAY   = 8'h10;
  localparam logic [7:0] ADDR_BAND    = 8'h14;
  localparam logic [7:0] ADDR_GAIN    = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_MASK    = 8'h20;
  localparam logic [7:0] ADDR_STATE   = 8'h24;
  localparam logic [7:0] ADDR_MODEL   = 8'h28;
  // Fields of special_function_select
  localparam int SEL_TYPE_LOW  = 8;
  localparam int SEL_TYPE_HIGH = 9;
  localparam int SEL_OVS       = 10;
  localparam int SEL_AFT       = 15;
  // Status and mask bits
  localparam int STS_REV_POS   = 0;
  localparam int STS_REV_NEG   = 1;
  localparam int STS_APPLIED   = 2;
  localparam int STS_PARAM_ERR = 3;
  // Ranges
  localparam int AMT_MIN      = -1;
  localparam int AMT_MAX      = 200;
  localparam int OFS_MIN      = -100;
  localparam int OFS_MAX      = 100;
  localparam int DLY_MAX_MS   = 2000;
  localparam int BAND_MAX_UM  = 100;
  localparam logic [6:0] BAND_ZERO_UM = 7'h02;
  // Scaling: one stall percent in torque units
  localparam int TORQUE_PER_PCT = 100;
  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h1000;
  localparam logic [3:0]  RST_MASK = 4'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DELAY_UNIT_MS = 1;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = DELAY_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;
endpackage

// ==== core/lom_model.sv ====
`timescale 1ns/1ps
// Model position filter and reversal detector with dead band
module lom_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Command side
  input  wire logic        sample_tick,
  input  wire logic [31:0] pos_cmd,
  input  wire logic [15:0] gain,
  input  wire logic [6:0]  band,
  // Results
  output logic      [31:0] model_pos,
  output logic             dir_neg,
  output logic             rev,
  output logic             rev_neg
);
  typedef struct packed {
    logic [31:0] model;
    logic [31:0] peak;
    logic        known;
    logic        neg;
    logic        rev;
  } lom_model_s;
  lom_model_s q, d;
  logic signed [63:0] diff;
  logic signed [63:0] prod;
  logic signed [31:0] nm;
  logic signed [31:0] exc;

  always_comb begin
    d = q;
    d.rev = 1'b0;
    diff = 64'($signed(pos_cmd)) - 64'($signed(q.model));
    prod = diff * 64'($signed({1'b0, gain}));
    nm = $signed(q.model) + $signed(prod[47:16]);
    exc = q.neg ? nm - $signed(q.peak) : $signed(q.peak) - nm;
    if (sample_tick) begin
      d.model = nm;
      if ((q.neg && nm < $signed(q.peak)) || (!q.neg && nm > $signed(q.peak))) begin
        // Travel on the current side also fixes the direction, so the next turn counts
        d.peak  = nm;
        d.known = 1'b1;
      end else if (exc > $signed({25'h0, band})) begin
        d.peak  = nm;
        d.neg   = ~q.neg;
        d.known = 1'b1;
        d.rev   = q.known;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign model_pos = q.model;
  assign dir_neg   = q.neg;
  assign rev       = q.rev;
  assign rev_neg   = q.neg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rev_single_pulse: assert property (rev |=> !rev) else $error("reversal pulse longer than one cycle");
  a_rev_only_on_tick: assert property (!sample_tick |=> !rev && $stable(model_pos)) else $error("model moved off tick");
endmodule

// ==== core/lom_delay.sv ====
`timescale 1ns/1ps
// Millisecond delay timer for the compensation instant
module lom_delay #(
  parameter int CYC_PER_MS = lom_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Control
  input  wire logic        start,
  input  wire logic [10:0] delay_ms,
  // Result
  output logic             busy,
  output logic             fire
);
  typedef struct packed {
    logic        busy;
    logic [10:0] ms_left;
    logic [23:0] cyc;
    logic        fire;
  } lom_delay_s;
  lom_delay_s q, d;
  localparam logic [23:0] CYC_LAST = 24'(CYC_PER_MS - 1);

  always_comb begin
    d = q;
    d.fire = 1'b0;
    if (start) begin
      // A newer reversal replaces one still waiting
      d.busy    = 1'b1;
      d.ms_left = delay_ms;
      d.cyc     = '0;
    end else if (q.busy) begin
      if (q.ms_left == 11'h000) begin
        d.busy = 1'b0;
        d.fire = 1'b1;
      end else if (q.cyc == CYC_LAST) begin
        d.cyc     = '0;
        d.ms_left = q.ms_left - 11'h001;
      end else begin
        d.cyc = q.cyc + 24'h000001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign fire = q.fire;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_delay_zero_fire: assert property (start && delay_ms == 11'h000 ##1 !start |=> fire) else $error("zero delay late");
  a_fire_after_busy: assert property (fire |-> $past(busy)) else $error("fire without wait");
endmodule

// ==== test/lom_cnc.sv ====
// Motion controller model issuing sampled position commands
`timescale 1ns/1ps
module lom_cnc #(
  parameter int TICK_GAP = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Requested position
  input  wire logic [31:0] target,
  // Servo command
  output logic             sample_tick,
  output logic      [31:0] pos_cmd
);
  int cnt;
  // Command moves only with its tick, so the block never sees a half-updated value
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      sample_tick <= 1'b0;
      pos_cmd <= 32'h00000000;
    end else begin
      sample_tick <= (cnt == TICK_GAP - 1);
      cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
      if (cnt == TICK_GAP - 1) begin
        pos_cmd <= target;
      end
    end
  end
endmodule

// ==== test/lom_tb.sv ====
// Self-checking testbench of the lost motion compensation block
`timescale 1ns/1ps
module tb;
  localparam int CPM = 10;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_tick;
  logic [31:0] pos_cmd;
  logic [31:0] target    = 32'h00000000;
  logic        ff_active = 1'b0;
  logic [15:0] torque_in = 16'h012C;
  logic [15:0] torque_out;
  logic [15:0] collision_offset;
  logic        irq;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc;
  logic [7:0]  ra [5] = '{lom_pkg::ADDR_AMT_PRI, lom_pkg::ADDR_AMT_SEC, lom_pkg::ADDR_OFFSET,
                          lom_pkg::ADDR_DELAY, lom_pkg::ADDR_BAND};
  logic [31:0] bad [5] = '{32'h000000C9, 32'hFFFFFFFE, 32'h00000065, 32'h000007D1, 32'h00000065};
  logic [31:0] good [5] = '{32'h000000C8, 32'hFFFFFFFF, 32'hFFFFFF9C, 32'h000007D0, 32'h00000064};
  logic [15:0] sel [4] = '{16'h0300, 16'h0500, 16'h8100, 16'h8500};

  always #4 core_clk = ~core_clk;

  lom_cnc u_cnc (.core_clk(core_clk), .rstn(rstn), .target(target), .sample_tick(sample_tick), .pos_cmd(pos_cmd));

  lom_comp #(.CYC_PER_MS(CPM)) DUT (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
    .pos_cmd(pos_cmd), .ff_active(ff_active), .torque_in(torque_in), .torque_out(torque_out),
    .collision_offset(collision_offset), .irq(irq)
  );

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; left one idle edge after the completing edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int   n;
    logic done;
    done = 1'b0;
    rd = 32'h00000000;
    er = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && !done; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) begin
        rd = prdata;
        er = pslverr;
        done = 1'b1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (!done) begin
      error_cnt++;
      $display("wrong value at %0t: bus answer missing", $time);
      report_and_stop();
    end
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk1(er, 1'b0);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h00000000, rd, er);
    chk32(rd & msk, exp);
  endtask

  task rerr(input logic [7:0] a);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h00000000, rd, er);
    chk1(er, 1'b1);
    chk32(rd, 32'h00000000);
  endtask

  // Moves the command and reports the first torque deviation seen and when
  task comp(input logic [31:0] tgt, input logic [15:0] exp, output int c);
    int          n;
    logic        seen;
    logic [15:0] d;
    seen = 1'b0;
    d = 16'h0000;
    c = 0;
    target <= tgt;
    for (n = 0; n < 300; n++) begin
      @(negedge core_clk);
      if (!seen && torque_out !== torque_in) begin
        seen = 1'b1;
        d = torque_out - torque_in;
        c = n;
      end
      @(posedge core_clk);
    end
    chk32({16'h0000, d}, {16'h0000, exp});
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rchk(lom_pkg::ADDR_CTRL, 32'h00000000, 32'hFFFFFFFF);
    rchk(lom_pkg::ADDR_GAIN, 32'h00001000, 32'hFFFFFFFF);
    rchk(lom_pkg::ADDR_MASK, 32'h00000000, 32'hFFFFFFFF);
    rerr(8'h2C);
    rerr(8'h01);
    $display("test reset done");
    wreg(lom_pkg::ADDR_MASK, 32'h00000008);
    for (int i = 0; i < 4; i++) begin
      wreg(lom_pkg::ADDR_CTRL, {16'h0000, sel[i]});
      repeat (2) @(posedge core_clk);
      chk1(irq, 1'b1);
      rchk(lom_pkg::ADDR_STATUS, 32'h00000008, 32'h00000008);
      repeat (2) @(posedge core_clk);
      chk1(irq, 1'b0);
      rchk(lom_pkg::ADDR_CTRL, 32'h00000000, 32'hFFFFFFFF);
    end
    wreg(lom_pkg::ADDR_CTRL, 32'h00000100);
    rchk(lom_pkg::ADDR_CTRL, 32'h00000100, 32'hFFFFFFFF);
    wreg(lom_pkg::ADDR_CTRL, 32'h00000200);
    rchk(lom_pkg::ADDR_CTRL, 32'h00000200, 32'hFFFFFFFF);
    $display("test select done");
    for (int i = 0; i < 5; i++) begin
      wreg(ra[i], bad[i]);
      rchk(lom_pkg::ADDR_STATUS, 32'h00000008, 32'h00000008);
      rchk(ra[i], 32'h00000000, 32'hFFFFFFFF);
      wreg(ra[i], good[i]);
      rchk(ra[i], good[i], 32'hFFFFFFFF);
      wreg(ra[i], 32'h00000000);
    end
    $display("test ranges done");
    wreg(lom_pkg::ADDR_GAIN, 32'h00008000);
    wreg(lom_pkg::ADDR_AMT_PRI, 32'h0000000A);
    wreg(lom_pkg::ADDR_MASK, 32'h00000004);
    rchk(lom_pkg::ADDR_STATUS, 32'h00000000, 32'hFFFFFFFF);
    comp(32'h000007D0, 16'h0000, cyc);
    comp(32'hFFFFF830, 16'hFC18, cyc);
    chk1(cyc < 3 * CPM, 1'b1);
    chk1(irq, 1'b1);
    rchk(lom_pkg::ADDR_STATUS, 32'h00000006, 32'hFFFFFFFF);
    comp(32'h000007D0, 16'h03E8, cyc);
    $display("test reversal done");
    wreg(lom_pkg::ADDR_AMT_SEC, 32'hFFFFFFFF);
    wreg(lom_pkg::ADDR_OFFSET, 32'h00000005);
    comp(32'hFFFFF830, 16'h0000, cyc);
    comp(32'h000007D0, 16'h05DC, cyc);
    chk32({16'h0000, collision_offset}, 32'h000001F4);
    wreg(lom_pkg::ADDR_AMT_SEC, 32'h00000014);
    comp(32'hFFFFF830, 16'hFA24, cyc);
    $display("test offset done");
    wreg(lom_pkg::ADDR_DELAY, 32'h00000003);
    comp(32'h000007D0, 16'h05DC, cyc);
    chk1(cyc >= 3 * CPM, 1'b1);
    wreg(lom_pkg::ADDR_DELAY, 32'h00000000);
    $display("test delay done");
    wreg(lom_pkg::ADDR_BAND, 32'h00000032);
    ff_active <= 1'b1;
    comp(32'h000007B2, 16'h0000, cyc);
    ff_active <= 1'b0;
    comp(32'h00000794, 16'hFA24, cyc);
    $display("test dead band done");
    wreg(lom_pkg::ADDR_CTRL, 32'h00000000);
    comp(32'h000007D0, 16'h0000, cyc);
    wreg(lom_pkg::ADDR_CTRL, 32'h00000100);
    comp(32'hFFFFF830, 16'hFA24, cyc);
    $display("test type done");
    wreg(lom_pkg::ADDR_BAND, 32'h00000000);
    ff_active <= 1'b1;
    comp(32'hFFFFF833, 16'h0000, cyc);
    comp(32'hFFFFF834, 16'h05DC, cyc);
    ff_active <= 1'b0;
    $display("test zero band done");
    report_and_stop();
  end
endmodule
